// file: verilog/tmr_top.sv
// Added by the designer: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
module tmr_top
	import tmr_pkg::*;
(
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// wishbone slave
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [7:0]        wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	// clock sources and system status
	input  wire logic              fixed_clk_i,
	input  wire logic              loop_engaged_i,
	input  wire logic              debug_halt_i,
	// channel pins
	input  wire logic [NUM_CH-1:0] chan_pin_i,
	// interrupt requests
	output logic                   overflow_irq_o,
	output logic      [NUM_CH-1:0] chan_irq_o
);
	tmr_state_type st_q;
	tmr_state_type st_d;
	logic              acc;
	logic              wr;
	logic              rd;
	logic              tick;
	logic              tof_set;
	logic              cnt_wr;
	logic              fix_rise;
	logic [15:0]       tc;
	logic [7:0]        rbyte;
	logic [NUM_CH-1:0] rise;
	logic [NUM_CH-1:0] fall;
	logic [NUM_CH-1:0] cap;
	logic [NUM_CH-1:0] val_wr;

	// coherent 16-bit read: first byte read freezes the other one
	function automatic tmr_coh_type coh_read(input logic hi, input logic dbg, input logic [15:0] live,
		input tmr_coh_type cur, output logic [7:0] b);
		tmr_coh_type r;
		r = cur;
		if (dbg) begin
			// debug reads show the live value and leave the latch untouched
			b = hi ? live[15:8] : live[7:0];
		end else if (!cur.lat) begin
			b = hi ? live[15:8] : live[7:0];
			r.lat = 1'b1;
			r.first_hi = hi;
			r.hold = live;
		end else begin
			b = hi ? cur.hold[15:8] : cur.hold[7:0];
			if (hi != cur.first_hi) begin
				r.lat = 1'b0;
			end
		end
		return r;
	endfunction

	// next-state logic for the whole block
	always_comb begin
		st_d = st_q;
		acc = wb_cyc_i & wb_stb_i & ~st_q.ack;
		wr = acc & wb_we_i & wb_sel_i[0];
		rd = acc & ~wb_we_i;
		st_d.ack = acc;
		st_d.rdat = '0;
		rbyte = '0;
		cnt_wr = 1'b0;
		tof_set = 1'b0;
		val_wr = '0;
		// synchronizers: stage 0 feeds stage 1 only, edges seen on stages 1 and 2
		st_d.fix_sync = {st_q.fix_sync[1:0], fixed_clk_i};
		fix_rise = st_q.fix_sync[1] & ~st_q.fix_sync[2];
		for (int c = 0; c < NUM_CH; c++) begin
			st_d.ch[c].pin_sync = {st_q.ch[c].pin_sync[1:0], chan_pin_i[c]};
			rise[c] = st_q.ch[c].pin_sync[1] & ~st_q.ch[c].pin_sync[2];
			fall[c] = ~st_q.ch[c].pin_sync[1] & st_q.ch[c].pin_sync[2];
		end
		// tick source decode; an external clock above a quarter bus rate would lose edges
		case (st_q.css)
			CSS_OFF:   tick = 1'b0;
			CSS_BUS:   tick = 1'b1;
			CSS_FIXED: tick = loop_engaged_i ? fix_rise : 1'b1;
			CSS_EXT:   tick = rise[st_q.ext_sel];
			default:   tick = 1'b0;
		endcase
		// the counter freezes while the debugger halts the system
		tick = tick & ~debug_halt_i;
		tc = (st_q.modv == TMR_CNT_RST) ? TMR_FREE_TC : st_q.modv;
		// counting: one step per tick only
		if (!st_q.cpwm) begin
			st_d.dir_down = 1'b0;
		end
		if (tick) begin
			if (!st_q.cpwm) begin
				if (st_q.cnt == tc) begin
					st_d.cnt = TMR_CNT_RST;
					tof_set = 1'b1;
				end else begin
					st_d.cnt = st_q.cnt + 16'h0001;
				end
			end else if (!st_q.dir_down) begin
				if (st_q.cnt == tc) begin
					st_d.dir_down = 1'b1;
					st_d.cnt = st_q.cnt - 16'h0001;
					tof_set = 1'b1;
				end else begin
					st_d.cnt = st_q.cnt + 16'h0001;
				end
			end else begin
				if (st_q.cnt == TMR_CNT_RST) begin
					st_d.dir_down = 1'b0;
					st_d.cnt = st_q.cnt + 16'h0001;
				end else begin
					st_d.cnt = st_q.cnt - 16'h0001;
				end
			end
		end
		// capture decode per channel; center mode disables capture on every channel
		for (int c = 0; c < NUM_CH; c++) begin
			cap[c] = ~st_q.cpwm & (st_q.ch[c].mode == MODE_CAPTURE) &
				((rise[c] & st_q.ch[c].els[0]) | (fall[c] & st_q.ch[c].els[1]));
		end
		// register writes
		if (wr) begin
			case (wb_adr_i)
				TMR_CTRL_ADR: begin
					if (wb_dat_i[TC_TOF]) begin
						st_d.counter_overflow_flag = 1'b0;
					end
					st_d.overflow_irq_enable = wb_dat_i[TC_OVERFLOW_IRQ_ENABLE];
					st_d.cpwm = wb_dat_i[TC_CPWM];
					st_d.css = wb_dat_i[TC_CSS +: 2];
					st_d.ext_sel = wb_dat_i[TC_EXT +: CHW];
				end
				TMR_CNTH_ADR, TMR_CNTL_ADR: begin
					cnt_wr = 1'b1;
					st_d.cnt = TMR_CNT_RST;
					st_d.dir_down = 1'b0;
					st_d.cnt_coh.lat = 1'b0;
				end
				TMR_MODH_ADR: st_d.modv[15:8] = wb_dat_i[7:0];
				TMR_MODL_ADR: st_d.modv[7:0] = wb_dat_i[7:0];
				default: ;
			endcase
			for (int c = 0; c < NUM_CH; c++) begin
				if (wb_adr_i == 8'(TMR_CH_BASE + c * TMR_CH_STEP + TMR_CH_CTRL)) begin
					if (wb_dat_i[CC_FLAG]) begin
						st_d.ch[c].flag = 1'b0;
					end
					st_d.ch[c].ie = wb_dat_i[CC_IE];
					st_d.ch[c].mode = wb_dat_i[CC_MODE +: 2];
					st_d.ch[c].els = wb_dat_i[CC_ELS +: 2];
					st_d.ch[c].coh.lat = 1'b0;
				end
				// value writes are dropped in capture mode while center mode is off
				if (st_q.cpwm || st_q.ch[c].mode != MODE_CAPTURE) begin
					if (wb_adr_i == 8'(TMR_CH_BASE + c * TMR_CH_STEP + TMR_CH_VALH)) begin
						st_d.ch[c].val[15:8] = wb_dat_i[7:0];
					end
					if (wb_adr_i == 8'(TMR_CH_BASE + c * TMR_CH_STEP + TMR_CH_VALL)) begin
						st_d.ch[c].val[7:0] = wb_dat_i[7:0];
					end
				end
				val_wr[c] = (wb_adr_i == 8'(TMR_CH_BASE + c * TMR_CH_STEP + TMR_CH_VALH)) |
					(wb_adr_i == 8'(TMR_CH_BASE + c * TMR_CH_STEP + TMR_CH_VALL));
			end
		end
		// register reads
		if (rd) begin
			case (wb_adr_i)
				TMR_CTRL_ADR: begin
					rbyte[TC_TOF] = st_q.counter_overflow_flag;
					rbyte[TC_OVERFLOW_IRQ_ENABLE] = st_q.overflow_irq_enable;
					rbyte[TC_CPWM] = st_q.cpwm;
					rbyte[TC_CSS +: 2] = st_q.css;
					rbyte[TC_EXT +: CHW] = st_q.ext_sel;
				end
				TMR_CNTH_ADR, TMR_CNTL_ADR: begin
					st_d.cnt_coh = coh_read(wb_adr_i == TMR_CNTH_ADR, debug_halt_i, st_q.cnt, st_q.cnt_coh, rbyte);
				end
				TMR_MODH_ADR: rbyte = st_q.modv[15:8];
				TMR_MODL_ADR: rbyte = st_q.modv[7:0];
				default: ;
			endcase
			for (int c = 0; c < NUM_CH; c++) begin
				if (wb_adr_i == 8'(TMR_CH_BASE + c * TMR_CH_STEP + TMR_CH_CTRL)) begin
					rbyte[CC_FLAG] = st_q.ch[c].flag;
					rbyte[CC_IE] = st_q.ch[c].ie;
					rbyte[CC_MODE +: 2] = st_q.ch[c].mode;
					rbyte[CC_ELS +: 2] = st_q.ch[c].els;
				end
				if (wb_adr_i == 8'(TMR_CH_BASE + c * TMR_CH_STEP + TMR_CH_VALH) ||
					wb_adr_i == 8'(TMR_CH_BASE + c * TMR_CH_STEP + TMR_CH_VALL)) begin
					st_d.ch[c].coh = coh_read(wb_adr_i == 8'(TMR_CH_BASE + c * TMR_CH_STEP + TMR_CH_VALH),
						debug_halt_i, st_q.ch[c].val, st_q.ch[c].coh, rbyte);
				end
			end
			st_d.rdat = {24'h000000, rbyte};
		end
		// hardware sets come last so an event beats a same-cycle clear
		if (tof_set) begin
			st_d.counter_overflow_flag = 1'b1;
		end
		for (int c = 0; c < NUM_CH; c++) begin
			if (cap[c]) begin
				st_d.ch[c].val = st_q.cnt;
				st_d.ch[c].flag = 1'b1;
			end
			st_d.ch[c].irq = st_d.ch[c].flag & st_d.ch[c].ie;
		end
		st_d.ovf_irq = st_d.counter_overflow_flag & st_d.overflow_irq_enable;
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// outputs straight from the state register
	assign wb_dat_o = st_q.rdat;
	assign wb_ack_o = st_q.ack;
	assign overflow_irq_o = st_q.ovf_irq;
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			chan_irq_o[c] = st_q.ch[c].irq;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_stopped_hold: assert property ((st_q.css == CSS_OFF && !cnt_wr) |=> $stable(st_q.cnt))
		else $error("counter moved with clock source off");
	chk_wrap_flag: assert property ((!st_q.cpwm && tick && !cnt_wr && st_q.cnt == tc)
		|=> (st_q.cnt == 16'h0000 && st_q.counter_overflow_flag))
		else $error("up count did not wrap with overflow flag");
	chk_ovf_level: assert property (overflow_irq_o == (st_q.counter_overflow_flag && st_q.overflow_irq_enable))
		else $error("overflow interrupt level wrong");
	chk_center_turn: assert property ((st_q.cpwm && tick && !cnt_wr && !st_q.dir_down && st_q.cnt == tc)
		|=> (st_q.dir_down && st_q.cnt == $past(st_q.cnt) - 16'h0001 && st_q.counter_overflow_flag))
		else $error("center turn wrong");
	chk_counter_clear: assert property (cnt_wr |=> (st_q.cnt == 16'h0000 && !st_q.cnt_coh.lat))
		else $error("counter write did not clear");
	chk_bus_step: assert property ((st_q.css == CSS_BUS && !debug_halt_i && !st_q.cpwm && !cnt_wr && st_q.cnt != tc)
		|=> st_q.cnt == $past(st_q.cnt) + 16'h0001)
		else $error("bus clock did not step counter");
	chk_fixed_sync: assert property ((st_q.css == CSS_FIXED && loop_engaged_i && !fix_rise && !cnt_wr)
		|=> $stable(st_q.cnt))
		else $error("fixed clock stepped without synchronized edge");
	chk_capture_copy: assert property (cap[0] |=> (st_q.ch[0].val == $past(st_q.cnt) && st_q.ch[0].flag))
		else $error("capture did not store count");
	chk_capture_ro: assert property ((val_wr[0] && !st_q.cpwm && st_q.ch[0].mode == MODE_CAPTURE && !cap[0])
		|=> $stable(st_q.ch[0].val))
		else $error("capture value written by software");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held more than one cycle");

	cov_overflow: cover property (tof_set && st_q.overflow_irq_enable);
	cov_capture: cover property (cap[0] ##[1:20] rd);
	cov_center: cover property (st_q.cpwm && tick && !st_q.dir_down && st_q.cnt == tc);
endmodule

// file: verilog/tmr_pkg.sv
package tmr_pkg;
	localparam int NUM_CH = 2;
	localparam int CHW    = 1;
	// register byte addresses
	localparam logic [7:0] TMR_CTRL_ADR = 8'h00;
	localparam logic [7:0] TMR_CNTH_ADR = 8'h04;
	localparam logic [7:0] TMR_CNTL_ADR = 8'h08;
	localparam logic [7:0] TMR_MODH_ADR = 8'h0C;
	localparam logic [7:0] TMR_MODL_ADR = 8'h10;
	localparam logic [7:0] TMR_CH_BASE  = 8'h20;
	localparam logic [7:0] TMR_CH_STEP  = 8'h10;
	localparam logic [7:0] TMR_CH_CTRL  = 8'h00;
	localparam logic [7:0] TMR_CH_VALH  = 8'h04;
	localparam logic [7:0] TMR_CH_VALL  = 8'h08;
	// timer_control fields
	localparam int TC_TOF  = 7;
	localparam int TC_OVERFLOW_IRQ_ENABLE = 6;
	localparam int TC_CPWM = 5;
	localparam int TC_CSS  = 3;
	localparam int TC_EXT  = 0;
	// channel_control fields
	localparam int CC_FLAG = 7;
	localparam int CC_IE   = 6;
	localparam int CC_MODE = 4;
	localparam int CC_ELS  = 2;
	// reset values and the free-running terminal count
	localparam logic [7:0]  TMR_CTRL_RST = 8'h00;
	localparam logic [15:0] TMR_CNT_RST  = 16'h0000;
	localparam logic [15:0] TMR_FREE_TC  = 16'hFFFF;
	// clock sources and the channel capture mode
	localparam logic [1:0] CSS_OFF   = 2'h0;
	localparam logic [1:0] CSS_BUS   = 2'h1;
	localparam logic [1:0] CSS_FIXED = 2'h2;
	localparam logic [1:0] CSS_EXT   = 2'h3;
	localparam logic [1:0] MODE_CAPTURE = 2'h0;

	typedef struct packed {
		logic        lat;
		logic        first_hi;
		logic [15:0] hold;
	} tmr_coh_type;

	typedef struct packed {
		logic        flag;
		logic        ie;
		logic [1:0]  mode;
		logic [1:0]  els;
		logic [15:0] val;
		tmr_coh_type coh;
		logic [2:0]  pin_sync;
		logic        irq;
	} tmr_chan_type;

	typedef struct packed {
		logic [15:0]             cnt;
		logic                    dir_down;
		logic                    counter_overflow_flag;
		logic                    overflow_irq_enable;
		logic                    cpwm;
		logic [1:0]              css;
		logic [CHW-1:0]          ext_sel;
		logic [15:0]             modv;
		tmr_coh_type             cnt_coh;
		logic [2:0]              fix_sync;
		logic                    ack;
		logic [31:0]             rdat;
		logic                    ovf_irq;
		tmr_chan_type [NUM_CH-1:0] ch;
	} tmr_state_type;
endpackage

// file: dv/tmr_pin_src.sv
`timescale 1ns/1ps
// far-side model: event source and external clock on the channel pins
module tmr_pin_src
	import tmr_pkg::*;
(
	// bus clock, used only to pace the edges
	input  wire logic              clk_i,
	// channel pins
	output logic      [NUM_CH-1:0] pin_o
);
	// pins idle low until an event is commanded
	initial pin_o = '0;

	// move one pin just after a bus clock edge
	task automatic level(input int c, input logic v);
		@(posedge clk_i);
		pin_o[c] <= v;
	endtask

	// each phase lasts four bus cycles, well inside the quarter-rate limit
	task automatic pulse(input int c, input int n);
		repeat (n) begin
			level(c, 1'b1);
			repeat (3) @(posedge clk_i);
			level(c, 1'b0);
			repeat (3) @(posedge clk_i);
		end
	endtask
endmodule

// file: dv/tb_tmr_top.sv
`timescale 1ns/1ps
module tb_tmr_top
	import tmr_pkg::*;
;
	logic              clk_i;
	logic              rst_i;
	logic              wb_cyc_i;
	logic              wb_stb_i;
	logic              wb_we_i;
	logic [7:0]        wb_adr_i;
	logic [3:0]        wb_sel_i;
	logic [31:0]       wb_dat_i;
	logic [31:0]       wb_dat_o;
	logic              wb_ack_o;
	logic              fixed_clk_i;
	logic              loop_engaged_i;
	logic              debug_halt_i;
	logic [NUM_CH-1:0] chan_pin_i;
	logic              overflow_irq_o;
	logic [NUM_CH-1:0] chan_irq_o;
	logic [7:0]        rb;
	logic [15:0]       rw;
	int                n_errors;
	int                check_count;
	logic [1:0]        e;

	tmr_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.fixed_clk_i(fixed_clk_i), .loop_engaged_i(loop_engaged_i), .debug_halt_i(debug_halt_i),
		.chan_pin_i(chan_pin_i), .overflow_irq_o(overflow_irq_o), .chan_irq_o(chan_irq_o));
	tmr_pin_src partner (.clk_i(clk_i), .pin_o(chan_pin_i));

	// 200 MHz bus clock
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// classic single cycle: hold everything until ack is sampled high
	task automatic req(input logic [7:0] a, input logic w, input logic [7:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_dat_i <= {24'h000000, d};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rb = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req(a, 1'b1, d);
	endtask

	// high byte first, then low byte
	task automatic rd16(input logic [7:0] ah, input logic [7:0] al);
		req(ah, 1'b0, 8'h00);
		rw[15:8] = rb;
		req(al, 1'b0, 8'h00);
		rw[7:0] = rb;
	endtask

	// a hang counts as a mismatch and ends the run the normal way
	initial begin
		repeat (20000) @(posedge clk_i);
		n_errors++;
		conclude();
	end

	initial begin
		{rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
		{wb_adr_i, wb_dat_i, wb_sel_i} = '0;
		{fixed_clk_i, loop_engaged_i, debug_halt_i} = 3'h0;
		n_errors = 0;
		check_count = 0;
		repeat (20) @(posedge clk_i);
		rst_i    <= 1'b0;
		wb_sel_i <= 4'hF;
		req(TMR_CTRL_ADR, 1'b0, 8'h00);
		check(rb, 16'h0000);
		req(8'hFC, 1'b0, 8'h00);
		check(rb, 16'h0000);
		// external clock on channel 1 pin; channel 1 stays off its pin functions
		wr(TMR_CTRL_ADR, 8'h19);
		partner.pulse(1, 5);
		wr(TMR_CTRL_ADR, 8'h00);
		rd16(TMR_CNTH_ADR, TMR_CNTL_ADR);
		check(rw, 16'h0005);
		repeat (10) @(posedge clk_i);
		rd16(TMR_CNTH_ADR, TMR_CNTL_ADR);
		check(rw, 16'h0005);
		// fixed source through the synchronizer while the loop is engaged
		loop_engaged_i <= 1'b1;
		wr(TMR_CTRL_ADR, 8'h10);
		repeat (3) begin
			fixed_clk_i <= 1'b1;
			repeat (4) @(posedge clk_i);
			fixed_clk_i <= 1'b0;
			repeat (4) @(posedge clk_i);
		end
		repeat (6) @(posedge clk_i);
		wr(TMR_CTRL_ADR, 8'h00);
		rd16(TMR_CNTH_ADR, TMR_CNTL_ADR);
		check(rw, 16'h0008);
		// every edge select with a rise then a fall; flag cleared on each pass
		for (int i = 0; i < 4; i++) begin
			e = i[1:0];
			wr(TMR_CH_BASE + TMR_CH_CTRL, {4'hC, e, 2'h0});
			partner.level(0, 1'b1);
			repeat (8) @(posedge clk_i);
			req(TMR_CH_BASE + TMR_CH_CTRL, 1'b0, 8'h00);
			check(rb[7], e[0]);
			check(chan_irq_o[0], e[0]);
			partner.level(0, 1'b0);
			repeat (8) @(posedge clk_i);
			req(TMR_CH_BASE + TMR_CH_CTRL, 1'b0, 8'h00);
			check(rb[7], e != 2'h0);
		end
		// a write to a captured value is ignored
		wr(TMR_CH_BASE + TMR_CH_VALL, 8'h55);
		rd16(TMR_CH_BASE + TMR_CH_VALH, TMR_CH_BASE + TMR_CH_VALL);
		check(rw, 16'h0008);
		// first byte read freezes the other across a new capture
		req(TMR_CH_BASE + TMR_CH_VALH, 1'b0, 8'h00);
		wr(TMR_CTRL_ADR, 8'h19);
		partner.pulse(1, 3);
		wr(TMR_CTRL_ADR, 8'h00);
		partner.level(0, 1'b1);
		repeat (8) @(posedge clk_i);
		req(TMR_CH_BASE + TMR_CH_VALL, 1'b0, 8'h00);
		check(rb, 16'h0008);
		req(TMR_CH_BASE + TMR_CH_VALL, 1'b0, 8'h00);
		check(rb, 16'h000B);
		// any write to a counter byte clears it
		wr(TMR_CNTH_ADR, 8'h5A);
		rd16(TMR_CNTH_ADR, TMR_CNTL_ADR);
		check(rw, 16'h0000);
		// capture keeps working under debug halt
		debug_halt_i <= 1'b1;
		wr(TMR_CH_BASE + TMR_CH_CTRL, 8'hCC);
		partner.level(0, 1'b0);
		repeat (8) @(posedge clk_i);
		req(TMR_CH_BASE + TMR_CH_CTRL, 1'b0, 8'h00);
		check(rb, 16'h00CC);
		rd16(TMR_CH_BASE + TMR_CH_VALH, TMR_CH_BASE + TMR_CH_VALL);
		check(rw, 16'h0000);
		debug_halt_i <= 1'b0;
		// modulus wrap on the bus clock, flag holds until cleared
		wr(TMR_MODH_ADR, 8'h00);
		wr(TMR_MODL_ADR, 8'h03);
		wr(TMR_CTRL_ADR, 8'h48);
		repeat (10) @(posedge clk_i);
		check(overflow_irq_o, 1'b1);
		rd16(TMR_CNTH_ADR, TMR_CNTL_ADR);
		check(rw <= 16'h0003, 1'b1);
		wr(TMR_CTRL_ADR, 8'h40);
		repeat (4) @(posedge clk_i);
		req(TMR_CTRL_ADR, 1'b0, 8'h00);
		check(rb, 16'h00C0);
		wr(TMR_CTRL_ADR, 8'hC0);
		req(TMR_CTRL_ADR, 1'b0, 8'h00);
		check(rb, 16'h0040);
		check(overflow_irq_o, 1'b0);
		// center mode: six bus ticks from zero climb to three and fall back to zero
		wr(TMR_CNTL_ADR, 8'h00);
		wr(TMR_CTRL_ADR, 8'h28);
		repeat (3) @(posedge clk_i);
		wr(TMR_CTRL_ADR, 8'h20);
		rd16(TMR_CNTH_ADR, TMR_CNTL_ADR);
		check(rw, 16'h0000);
		req(TMR_CTRL_ADR, 1'b0, 8'h00);
		check(rb, 16'h00A0);
		check(overflow_irq_o, 1'b0);
		// fixed source with the loop disengaged ticks every bus cycle, wrapping at modulus
		loop_engaged_i <= 1'b0;
		wr(TMR_CNTL_ADR, 8'h00);
		wr(TMR_CTRL_ADR, 8'h10);
		repeat (3) @(posedge clk_i);
		wr(TMR_CTRL_ADR, 8'h00);
		rd16(TMR_CNTH_ADR, TMR_CNTL_ADR);
		check(rw, 16'h0002);
		conclude();
	end
endmodule
